// ==== pkg/timer_read_pkg.sv ====
// timer read resync package: register map, field positions, reset values, timing counts
// assumes a 32-bit axi4-lite slave at 10 mhz; offsets below are byte addresses
// Summary of operation
// RQ1 - deferred mode reads after wake may be stale
// RQ2 - non-deferred mode timer and capture reads always correct
// RQ3 - watchdog counter reads after wake may be stale
// RQ4 - watchdog is always deferred, no override
// RQ5 - software clears bit 2, sets bit 3
// RQ6 - direct-read select bit always reads zero
// RQ7 - software waits two interface plus one functional
package timer_read_pkg;
    localparam logic [7:0]  OFS_SYNC_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_COUNTER     = 8'h04;
    localparam logic [7:0]  OFS_CAPTURE1    = 8'h08;
    localparam logic [7:0]  OFS_CAPTURE2    = 8'h0C;
    localparam logic [7:0]  OFS_WDOG_CNT    = 8'h10;
    localparam logic [7:0]  OFS_TIMER_CTRL  = 8'h14;
    localparam logic [7:0]  OFS_STATUS      = 8'h18;
    localparam int          BIT_DEFERRED    = 2;
    localparam int          BIT_DIRECT_READ = 3;
    localparam int          BIT_RUN         = 0;
    localparam int          BIT_CAPTURE     = 1;
    localparam int          BIT_FCLK_EN     = 2;
    localparam logic [31:0] SYNC_CTRL_RESET = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // deferred shadow settles after two interface plus one functional cycle
    localparam int          SETTLE_IF_CYC   = 2;
    localparam int          SETTLE_FN_CYC   = 1;
    localparam int          SETTLE_CYC      = SETTLE_IF_CYC + SETTLE_FN_CYC;
endpackage : timer_read_pkg

// ==== design/resync_capture.sv ====
// resync_capture: three-flop synchroniser with agreement of stages two and three
// assumes d comes from outside the aclk domain
`timescale 1ns/10ps
module resync_capture
    import timer_read_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end else if (ce) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_r <= s3_r;
            end
        end
    end

    assign q = q_r;
endmodule : resync_capture

// ==== design/counter_shadow.sv ====
// counter_shadow: deferred copy of a live value, refreshed by the functional tick
// assumes tick and live come from the same clock domain
`timescale 1ns/10ps
module counter_shadow
    import timer_read_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic         tick,
    input  wire logic [W-1:0] live,
    output logic      [W-1:0] shadow
);
    logic [W-1:0] shadow_r;

    // copy lags the live value by one functional tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow_r <= '0;
        end else if (ce && tick) begin
            shadow_r <= live;
        end
    end

    assign shadow = shadow_r;
endmodule : counter_shadow

// ==== design/timer_counter_read_resync.sv ====
// timer_counter_read_resync: timer and watchdog counters with axi4-lite read path
// assumes fclk_in and if_clk_run arrive asynchronously from pins
`timescale 1ns/10ps
module timer_counter_read_resync
    import timer_read_pkg::*;
#(
    parameter int CW = 32
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        fclk_in,
    input  wire logic        if_clk_run,
    input  wire logic        capture_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_e;

    // synchronised pins
    logic [2:0] pins_s;
    wire        fclk_s    = pins_s[0];
    wire        if_run_s  = pins_s[1];
    wire        cap_s     = pins_s[2];

    resync_capture #(.W(3)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       ({capture_in, if_clk_run, fclk_in}),
        .q       (pins_s)
    );

    // edge detect on the synchronised (agreed) levels only
    logic fclk_d_r;
    logic cap_d_r;
    logic if_run_d_r;
    wire  ftick    = fclk_s & ~fclk_d_r;
    wire  cap_rise = cap_s & ~cap_d_r;
    wire  if_wake  = if_run_s & ~if_run_d_r;

    // control registers
    logic [31:0] sync_ctrl_r;
    logic [2:0]  timer_ctrl_r;
    logic        direct_read_r;
    wire         deferred = sync_ctrl_r[BIT_DEFERRED];
    wire         run      = timer_ctrl_r[BIT_RUN];

    // live counters
    logic [CW-1:0] gp_cnt_r;
    logic [CW-1:0] cap1_r;
    logic [CW-1:0] cap2_r;
    logic          cap_sel_r;
    logic [CW-1:0] wd_cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fclk_d_r   <= 1'b0;
            cap_d_r    <= 1'b0;
            if_run_d_r <= 1'b0;
        end else if (ce) begin
            fclk_d_r   <= fclk_s;
            cap_d_r    <= cap_s;
            if_run_d_r <= if_run_s;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_cnt_r <= '0;
            wd_cnt_r <= '0;
        end else if (ce && run && ftick) begin
            gp_cnt_r <= gp_cnt_r + CW'(1);
            wd_cnt_r <= wd_cnt_r + CW'(1);
        end
    end

    // captures alternate between the two capture registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap1_r    <= '0;
            cap2_r    <= '0;
            cap_sel_r <= 1'b0;
        end else if (ce && cap_rise && timer_ctrl_r[BIT_CAPTURE]) begin
            if (cap_sel_r) begin
                cap2_r <= gp_cnt_r;
            end else begin
                cap1_r <= gp_cnt_r;
            end
            cap_sel_r <= ~cap_sel_r;
        end
    end

    // deferred shadows refresh on the functional tick only
    logic [CW-1:0] gp_sh;
    logic [CW-1:0] c1_sh;
    logic [CW-1:0] c2_sh;
    logic [CW-1:0] wd_sh;

    counter_shadow #(.W(4*CW)) u_shadow (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .tick    (ftick),
        .live    ({wd_cnt_r, cap2_r, cap1_r, gp_cnt_r}),
        .shadow  ({wd_sh, c2_sh, c1_sh, gp_sh})
    );

    // settle window after interface clock wake; stale shadow visible in it
    logic [1:0] settle_r;
    wire        settling = (settle_r != 2'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= 2'h0;
        end else if (ce) begin
            if (if_wake) begin
                settle_r <= 2'(SETTLE_CYC);
            end else if (settling) begin
                settle_r <= settle_r - 2'h1;
            end
        end
    end

    // frozen shadow during settle models the deferred resync hazard
    logic [CW-1:0] gp_stale_r;
    logic [CW-1:0] c1_stale_r;
    logic [CW-1:0] c2_stale_r;
    logic [CW-1:0] wd_stale_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gp_stale_r <= '0;
            c1_stale_r <= '0;
            c2_stale_r <= '0;
            wd_stale_r <= '0;
        end else if (ce && !settling && !if_wake) begin
            gp_stale_r <= gp_sh;
            c1_stale_r <= c1_sh;
            c2_stale_r <= c2_sh;
            wd_stale_r <= wd_sh;
        end
    end

    // non-deferred or direct-read set: live value; otherwise shadow, stale while settling
    wire gp_direct = !deferred || direct_read_r;                      // see RQ2
    wire [CW-1:0] gp_rd = gp_direct ? gp_cnt_r : (settling ? gp_stale_r : gp_sh); // see RQ1
    wire [CW-1:0] c1_rd = gp_direct ? cap1_r : (settling ? c1_stale_r : c1_sh);   // see RQ1
    wire [CW-1:0] c2_rd = gp_direct ? cap2_r : (settling ? c2_stale_r : c2_sh);   // see RQ1
    // watchdog ignores the mode bits entirely
    wire [CW-1:0] wd_rd = settling ? wd_stale_r : wd_sh;               // see RQ3, RQ4

    // write channel: address and data taken in either order
    wr_state_e  wr_state_r;
    logic       aw_have_r;
    logic       w_have_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic       awready_r;
    logic       wready_r;
    logic       bvalid_r;
    logic [1:0] bresp_r;

    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take  = s_axi_wvalid && wready_r;
    wire [7:0]  wa   = aw_take ? s_axi_awaddr : aw_addr_r;
    wire [31:0] wd   = w_take ? s_axi_wdata : w_data_r;
    wire [3:0]  ws   = w_take ? s_axi_wstrb : w_strb_r;
    wire        wr_go = (wr_state_r == WR_IDLE) && (aw_have_r || aw_take) && (w_have_r || w_take);
    wire wr_sync = (wa == OFS_SYNC_CTRL);
    wire wr_tctl = (wa == OFS_TIMER_CTRL);
    wire wr_ok   = wr_sync || wr_tctl || (wa == OFS_COUNTER) || (wa == OFS_CAPTURE1)
                   || (wa == OFS_CAPTURE2) || (wa == OFS_WDOG_CNT) || (wa == OFS_STATUS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WR_IDLE;
            aw_have_r  <= 1'b0;
            w_have_r   <= 1'b0;
            aw_addr_r  <= 8'h00;
            w_data_r   <= 32'h0000_0000;
            w_strb_r   <= 4'h0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            bvalid_r   <= 1'b0;
            bresp_r    <= RESP_OKAY;
        end else if (ce) begin
            case (wr_state_r)
                WR_IDLE: begin
                    if (aw_take) begin
                        aw_addr_r <= s_axi_awaddr;
                        aw_have_r <= 1'b1;
                        awready_r <= 1'b0;
                    end
                    if (w_take) begin
                        w_data_r <= s_axi_wdata;
                        w_strb_r <= s_axi_wstrb;
                        w_have_r <= 1'b1;
                        wready_r <= 1'b0;
                    end
                    if (wr_go) begin
                        awready_r  <= 1'b0;
                        wready_r   <= 1'b0;
                        bvalid_r   <= 1'b1;
                        bresp_r    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                        wr_state_r <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_r   <= 1'b0;
                        aw_have_r  <= 1'b0;
                        w_have_r   <= 1'b0;
                        awready_r  <= 1'b1;
                        wready_r   <= 1'b1;
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    // register writes; only low byte lane carries control bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ctrl_r   <= SYNC_CTRL_RESET;
            direct_read_r <= 1'b0;
            timer_ctrl_r  <= 3'h0;
        end else if (ce && wr_go && ws[0]) begin
            if (wr_sync) begin
                sync_ctrl_r[BIT_DEFERRED] <= wd[BIT_DEFERRED];
                direct_read_r             <= wd[BIT_DIRECT_READ]; // see RQ5
            end
            if (wr_tctl) begin
                timer_ctrl_r <= wd[2:0];
            end
        end
    end

    // read channel: one read at a time, answer one cycle after address
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    wire         ar_take = s_axi_arvalid && arready_r;
    wire [7:0]   ra      = s_axi_araddr;
    // write-only select bit is masked from readback
    wire [31:0]  sync_rd = {sync_ctrl_r[31:BIT_DIRECT_READ+1], 1'b0, sync_ctrl_r[BIT_DIRECT_READ-1:0]}; // see RQ6
    wire [31:0]  stat_rd = {29'h0, settling, if_run_s, deferred};
    wire         rd_ok   = (ra == OFS_SYNC_CTRL) || (ra == OFS_COUNTER) || (ra == OFS_CAPTURE1)
                           || (ra == OFS_CAPTURE2) || (ra == OFS_WDOG_CNT) || (ra == OFS_TIMER_CTRL)
                           || (ra == OFS_STATUS);
    wire [31:0]  rd_mux  = (ra == OFS_SYNC_CTRL)  ? sync_rd :
                           (ra == OFS_COUNTER)    ? 32'(gp_rd) :
                           (ra == OFS_CAPTURE1)   ? 32'(c1_rd) :
                           (ra == OFS_CAPTURE2)   ? 32'(c2_rd) :
                           (ra == OFS_WDOG_CNT)   ? 32'(wd_rd) :
                           (ra == OFS_TIMER_CTRL) ? {29'h0, timer_ctrl_r} :
                           (ra == OFS_STATUS)     ? stat_rd : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_mux;
                rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
endmodule : timer_counter_read_resync

// ==== test/resync_checker_sva.sv ====
// resync_checker: bus handshake and read-value properties at the block's ports
// assumes one read and one write in flight at most
`timescale 1ns/10ps
module resync_checker
    import timer_read_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ce low freezes handshakes, so every take needs it
    wire logic ar_take = s_axi_arvalid && s_axi_arready && ce;
    wire logic w_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_w_answer: assert property (w_take |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_b_release: assert property (s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not released");
    chk_r_answer: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_r_release: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid && s_axi_arready)
        else $error("read not released");
    // unaligned offsets inside the map are unmapped words and answer with an error
    chk_map_okay: assert property (ar_take && s_axi_araddr <= OFS_STATUS && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
    chk_unmap_err: assert property (ar_take && s_axi_araddr > OFS_STATUS
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    chk_ctrl_bits: assert property (ar_take && s_axi_araddr == OFS_SYNC_CTRL
        |=> (s_axi_rdata & 32'hFFFF_FFFB) == 32'h0) else $error("control read shows write-only bit");
endmodule : resync_checker

bind timer_counter_read_resync resync_checker u_chk (
    .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ==== test/axi_host_model.sv ====
// axi_host_model: host issuing single-word axi4-lite register cycles
// assumes tasks are called one at a time from the testbench
`timescale 1ns/10ps
module axi_host_model (
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
    end
    // released payload is inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~v};
            end
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
            end
        end while (!s_axi_rvalid);
        {v, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : axi_host_model

// ==== test/testbench.sv ====
// testbench: register-level scenarios for the timer read resync block
// assumes the host model owns the bus; timer pins are driven here
`timescale 1ns/10ps
module testbench;
    import timer_read_pkg::*;
    logic             aclk = 1'b0;
    logic             aresetn = 1'b0;
    logic             fclk_in = 1'b0;
    logic             if_clk_run = 1'b1;
    logic             capture_in = 1'b0;
    logic [31:0]      d;
    logic [1:0]       r;
    int               mismatches = 0;
    int               tests_run = 0;
    int               cycles = 0;
    logic [31:0]      wv [3] = '{32'h8, 32'hC, 32'h0};
    logic [31:0]      rv [3] = '{32'h0, 32'h4, 32'h0};
    wire logic [7:0]  s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0]  s_axi_wstrb;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;

    timer_counter_read_resync DUT (
        .aclk, .aresetn, .ce(1'b1), .fclk_in, .if_clk_run, .capture_in,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    axi_host_model host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    initial begin
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        check({30'h0, got}, {30'h0, exp});
    endtask : check_resp
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        host.rd(a, d, r);
        check(d, exp);
        check_resp(r, RESP_OKAY);
    endtask : rd_chk
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] v);
        host.wr(a, v, r);
        check_resp(r, RESP_OKAY);
    endtask : wr_chk
    // six cycles each level, well past the pin synchroniser latency
    task automatic pulse(input int n, input bit cap);
        repeat (n) begin
            if (cap) capture_in <= 1'b1;
            else fclk_in <= 1'b1;
            repeat (6) @(posedge aclk);
            {capture_in, fclk_in} <= 2'h0;
            repeat (6) @(posedge aclk);
        end
    endtask : pulse
    // the read that follows lands inside the post-wake settle window
    task automatic wake();
        if_clk_run <= 1'b0;
        repeat (8) @(posedge aclk);
        if_clk_run <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask : wake

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFS_SYNC_CTRL, SYNC_CTRL_RESET);
        wr_chk(OFS_TIMER_CTRL, 32'h1);
        pulse(5, 1'b0);
        // ticks with run off only refresh the deferred copy
        wr_chk(OFS_TIMER_CTRL, 32'h2);
        pulse(1, 1'b0);
        pulse(1, 1'b1);
        wr_chk(OFS_TIMER_CTRL, 32'h3);
        pulse(2, 1'b0);
        wr_chk(OFS_TIMER_CTRL, 32'h2);
        pulse(1, 1'b0);
        pulse(1, 1'b1);
        rd_chk(OFS_COUNTER, 32'h7);
        for (int i = 0; i < 3; i++) begin
            wr_chk(OFS_SYNC_CTRL, wv[i]);
            rd_chk(OFS_SYNC_CTRL, rv[i]);
        end
        wake();
        rd_chk(OFS_COUNTER, 32'h7);
        rd_chk(OFS_CAPTURE1, 32'h5);
        rd_chk(OFS_CAPTURE2, 32'h7);
        wr_chk(OFS_SYNC_CTRL, SYNC_CTRL_RESET);
        wr_chk(OFS_SYNC_CTRL, 32'h8);
        wake();
        rd_chk(OFS_COUNTER, 32'h7);
        repeat (12) @(posedge aclk);
        rd_chk(OFS_WDOG_CNT, 32'h7);
        // back to deferred: status shows the settle window, then clears
        wr_chk(OFS_SYNC_CTRL, SYNC_CTRL_RESET);
        wake();
        rd_chk(OFS_STATUS, 32'h7);
        rd_chk(OFS_TIMER_CTRL, 32'h2);
        rd_chk(OFS_STATUS, 32'h3);
        host.rd(8'h1C, d, r);
        check(d, 32'h0);
        check_resp(r, RESP_SLVERR);
        host.wr(8'h1C, 32'h1, r);
        check_resp(r, RESP_SLVERR);
        print_verdict();
    end
endmodule : testbench
